// >>> rtl/acs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer (
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic       CE_I,
  input  wire logic       CTRL_WR_I,
  input  wire logic       INPUT_CFG_LO_I,
  input  wire logic       INPUT_CFG_HI_I,
  input  wire logic       SEQUENCE_SEL_LO_I,
  input  wire logic       SEQUENCE_SEL_HI_I,
  input  wire logic       CHAN_ADDR_LO_I,
  input  wire logic       CHAN_ADDR_HI_I,
  input  wire logic       REF_SEL_I,
  input  wire logic       SAMPLE_START_N_I,
  output logic            BUSY_O,
  output logic            SAMPLE_O,
  output logic [1:0]      CHAN_O,
  output logic            SINGLE_ENDED_O,
  output logic            PSEUDO_DIFF_O,
  output logic            FULL_DIFF_O,
  output logic            NEG_TO_GND_O,
  output logic            INT_REF_EN_O,
  output logic            REF_PIN_DRIVE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Control register latched on the write strobe.

  logic [1:0] cfg_r;
  logic [1:0] seq_r;
  logic [1:0] addr_r;
  logic       ref_r;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cfg_r     <= 2'h0;
      seq_r     <= 2'h0;
      addr_r    <= 2'h0;
      ref_r     <= 1'b0;
    end else if (CE_I) begin
      if (CTRL_WR_I) begin
        cfg_r  <= {INPUT_CFG_HI_I, INPUT_CFG_LO_I};
        seq_r  <= {SEQUENCE_SEL_HI_I, SEQUENCE_SEL_LO_I};
        addr_r <= {CHAN_ADDR_HI_I, CHAN_ADDR_LO_I};
        ref_r  <= REF_SEL_I;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Convert start edge detection and conversion timing.

  logic start_n_d_r;
  logic start_fall;
  logic conv_busy;
  logic conv_done;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      start_n_d_r <= 1'b1;
    end else if (CE_I) begin
      start_n_d_r <= SAMPLE_START_N_I;
    end
  end

  assign start_fall = start_n_d_r && !SAMPLE_START_N_I;

  acs_conv_timer u_timer (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .ce_i    (CE_I),
    .start_i (start_fall),
    .busy_o  (conv_busy),
    .done_o  (conv_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Channel pointer for the consecutive sequence.

  logic       seq_on;
  logic [1:0] ptr_r;
  logic [1:0] chan_nxt;

  assign seq_on = (seq_r == 2'b11);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ptr_r <= acs_pkg::CHAN_RESET;
    end else if (CE_I) begin
      if (CTRL_WR_I) begin
        ptr_r <= acs_pkg::CHAN_FIRST;
      end else if (conv_done && seq_on) begin
        if (ptr_r == addr_r) begin
          ptr_r <= acs_pkg::CHAN_FIRST;
        end else begin
          ptr_r <= ptr_r + 2'h1;
        end
      end
    end
  end

  // Undefined sequence codes fall back to direct addressing.
  assign chan_nxt = seq_on ? ptr_r : addr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      BUSY_O   <= 1'b0;
      SAMPLE_O <= 1'b0;
      CHAN_O   <= acs_pkg::CHAN_RESET;
    end else if (CE_I) begin
      BUSY_O   <= conv_busy || start_fall;
      SAMPLE_O <= start_fall && !conv_busy;
      // The mux holds its channel while converting.
      if (!conv_busy && !start_fall) begin
        CHAN_O <= chan_nxt;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      SINGLE_ENDED_O  <= 1'b1;
      PSEUDO_DIFF_O   <= 1'b0;
      FULL_DIFF_O     <= 1'b0;
      NEG_TO_GND_O    <= 1'b1;
      INT_REF_EN_O    <= 1'b0;
      REF_PIN_DRIVE_O <= 1'b0;
    end else if (CE_I) begin
      SINGLE_ENDED_O  <= (cfg_r == acs_pkg::ACS_CFG_SINGLE);
      NEG_TO_GND_O    <= (cfg_r == acs_pkg::ACS_CFG_SINGLE);
      PSEUDO_DIFF_O   <= (cfg_r == acs_pkg::ACS_CFG_PSEUDO);
      FULL_DIFF_O     <= (cfg_r == acs_pkg::ACS_CFG_DIFF);
      INT_REF_EN_O    <= ref_r;
      REF_PIN_DRIVE_O <= ref_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_pseudo;
    @(posedge CLK_I) disable iff (RST_I)
      CE_I && cfg_r == 2'b01 |=> PSEUDO_DIFF_O && !FULL_DIFF_O;
  endproperty
  a_pseudo: assert property (p_pseudo) else $error("pseudo mode wrong");

  property p_direct;
    @(posedge CLK_I) disable iff (RST_I)
      CE_I && seq_r == 2'b00 && !conv_busy && !start_fall
      |=> CHAN_O == $past(addr_r);
  endproperty
  a_direct: assert property (p_direct) else $error("direct chan wrong");

  property p_first;
    @(posedge CLK_I) disable iff (RST_I)
      CE_I && CTRL_WR_I |=> ptr_r == 2'h0;
  endproperty
  a_first: assert property (p_first) else $error("ptr not reset");

  property p_wrap;
    @(posedge CLK_I) disable iff (RST_I)
      CE_I && !CTRL_WR_I && conv_done && seq_on && ptr_r == addr_r
      |=> ptr_r == 2'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");

  property p_step;
    @(posedge CLK_I) disable iff (RST_I)
      CE_I && !CTRL_WR_I && conv_done && seq_on && ptr_r != addr_r
      |=> ptr_r == $past(ptr_r) + 2'h1;
  endproperty
  a_step: assert property (p_step) else $error("no step");

  property p_hold;
    @(posedge CLK_I) disable iff (RST_I)
      CE_I && !CTRL_WR_I && !conv_done |=> $stable(ptr_r);
  endproperty
  a_hold: assert property (p_hold) else $error("ptr moved");

  property p_ref;
    @(posedge CLK_I) disable iff (RST_I)
      CE_I |=> REF_PIN_DRIVE_O == $past(ref_r);
  endproperty
  a_ref: assert property (p_ref) else $error("ref drive wrong");

  property p_single;
    @(posedge CLK_I) disable iff (RST_I)
      CE_I && cfg_r == 2'b00 |=> NEG_TO_GND_O && SINGLE_ENDED_O;
  endproperty
  a_single: assert property (p_single) else $error("single wrong");

  property p_busy;
    @(posedge CLK_I) disable iff (RST_I)
      CE_I && start_fall && !conv_busy |=> BUSY_O;
  endproperty
  a_busy: assert property (p_busy) else $error("busy missing");

  property p_busy_hold;
    @(posedge CLK_I) disable iff (RST_I)
      conv_busy |-> BUSY_O;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy gap");

  property p_diff;
    @(posedge CLK_I) disable iff (RST_I)
      CE_I && cfg_r == 2'b10
      |=> FULL_DIFF_O && !PSEUDO_DIFF_O && !SINGLE_ENDED_O && !NEG_TO_GND_O;
  endproperty
  a_diff: assert property (p_diff) else $error("diff mode wrong");

  property p_extref;
    @(posedge CLK_I) disable iff (RST_I)
      CE_I && !ref_r |=> !INT_REF_EN_O && !REF_PIN_DRIVE_O;
  endproperty
  a_extref: assert property (p_extref) else $error("int ref on");

  // A low enable must freeze the pointer, the mux, busy and the config register.
  property p_frozen;
    @(posedge CLK_I) disable iff (RST_I)
      !CE_I |=> $stable(ptr_r) && $stable(CHAN_O) && $stable(BUSY_O)
        && $stable(cfg_r);
  endproperty
  a_frozen: assert property (p_frozen) else $error("state moved");

endmodule
`default_nettype wire

// >>> rtl/acs_pkg.sv
package acs_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  // Conversion time in ns (fourteen converter clocks at the nominal rate).
  localparam int unsigned CONV_TIME_NS  = 1400;
  localparam int unsigned CONV_CYCLES   =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  CONV_LAST     = 4'(CONV_CYCLES - 1);

  localparam logic [1:0]  CHAN_RESET    = 2'h0;
  localparam logic [1:0]  CHAN_FIRST    = 2'h0;

  typedef enum logic [1:0] {
    ACS_CFG_SINGLE = 2'b00,
    ACS_CFG_PSEUDO = 2'b01,
    ACS_CFG_DIFF   = 2'b10,
    ACS_CFG_RSVD   = 2'b11
  } acs_cfg_e;

  typedef enum logic [0:0] {
    ACS_IDLE = 1'b0,
    ACS_CONV = 1'b1
  } acs_state_e;

endpackage

// >>> rtl/acs_conv_timer.sv
`timescale 1ns/1ps
`default_nettype none
module acs_conv_timer (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);

  logic [3:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= 4'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (!busy_o && start_i) begin
        busy_o <= 1'b1;
        cnt_r  <= 4'h0;
      end else if (busy_o) begin
        if (cnt_r == acs_pkg::CONV_LAST) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> dv/acs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
  input  wire logic       clk_i,
  input  wire logic       busy_i,
  input  wire logic       sample_i,
  input  wire logic [1:0] chan_i,
  output logic            wr_o,
  output logic [6:0]      bits_o,
  output logic            start_n_o
);
  initial begin
    wr_o = 1'b0;
    bits_o = 7'h00;
    start_n_o = 1'b1;
  end

  // The strobe drops back to idle after one clock, so the inverted bits that follow are never latched.
  task automatic write(input logic [6:0] b);
    @(posedge clk_i);
    wr_o <= 1'b1;
    bits_o <= b;
    @(posedge clk_i);
    wr_o <= 1'b0;
    bits_o <= ~b;
  endtask

  // Start is held low through the conversion and raised once busy drops.
  task automatic start(output logic [1:0] ch, output int nb);
    ch = 2'h0;
    nb = 0;
    @(posedge clk_i);
    start_n_o <= 1'b0;
    for (int n = 0; n < 40 && nb == 0; n++) begin
      @(posedge clk_i);
      if (sample_i === 1'b1) begin
        ch = chan_i;
        nb = 1;
      end
    end
    while (nb > 0 && nb < 40) begin
      @(posedge clk_i);
      if (busy_i !== 1'b1) break;
      nb++;
    end
    start_n_o <= 1'b1;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ce = 1'b1;
  logic       wr, start_n, busy, sample, se, pd, fd, ng, ir, rd;
  logic [6:0] b;
  logic [1:0] chan;
  int         mismatches = 0;
  int         n_tests = 0;
  integer     seed = 32'h1676;

  always #50 clk = ~clk;

  acs_host_model i_host (.clk_i(clk), .busy_i(busy), .sample_i(sample),
    .chan_i(chan), .wr_o(wr), .bits_o(b), .start_n_o(start_n));

  acs_sequencer i_dut (.CLK_I(clk), .RST_I(rst), .CE_I(ce), .CTRL_WR_I(wr),
    .INPUT_CFG_LO_I(b[0]), .INPUT_CFG_HI_I(b[1]), .SEQUENCE_SEL_LO_I(b[2]),
    .SEQUENCE_SEL_HI_I(b[3]), .CHAN_ADDR_LO_I(b[4]), .CHAN_ADDR_HI_I(b[5]),
    .REF_SEL_I(b[6]), .SAMPLE_START_N_I(start_n), .BUSY_O(busy),
    .SAMPLE_O(sample), .CHAN_O(chan), .SINGLE_ENDED_O(se),
    .PSEUDO_DIFF_O(pd), .FULL_DIFF_O(fd), .NEG_TO_GND_O(ng),
    .INT_REF_EN_O(ir), .REF_PIN_DRIVE_O(rd));

  function automatic logic [5:0] exp_dec(input logic [6:0] v);
    return {v[1:0] == 2'h0, v[1:0] == 2'h1, v[1:0] == 2'h2,
            v[1:0] == 2'h0, v[6], v[6]};
  endfunction

  // Codes other than 11 behave as direct addressing.
  function automatic logic [1:0] exp_ch(input logic [6:0] v, input int k);
    if (v[3:2] == 2'h3) return 2'(k % (int'(v[5:4]) + 1));
    return v[5:4];
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rst();
    chk("rst_dec", 8'(exp_dec(7'h00)), 8'({se, pd, fd, ng, ir, rd}));
    chk("rst_chan", 8'h00, 8'(chan));
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic run(input logic [6:0] v, input int m);
    logic [1:0] ch;
    int         nb;
    i_host.write(v);
    repeat (3) @(posedge clk);
    #1;
    chk("decode", 8'(exp_dec(v)), 8'({se, pd, fd, ng, ir, rd}));
    for (int k = 0; k < m; k++) begin
      i_host.start(ch, nb);
      chk("chan", 8'(exp_ch(v, k)), 8'(ch));
      chk("busy_len", 8'(acs_pkg::CONV_CYCLES + 1), 8'(nb));
    end
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_rst();
    // A frozen block must ignore a control write.
    @(posedge clk);
    ce <= 1'b0;
    i_host.write(7'h62);
    repeat (3) @(posedge clk);
    #1;
    chk_rst();
    @(posedge clk);
    ce <= 1'b1;
    run(7'h3C, 2);
    run(7'h2D, 7);
    run(7'h62, 2);
    run(7'h11, 2);
    // A reset in mid-run must bring back the reset decode and channel.
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_rst();
    for (int i = 0; i < 30; i++) begin
      run(7'($random(seed)), 3 + ($random(seed) & 3));
    end
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
